// *** src/io_board_addr_irq_select.sv ***
// The plain strobed port and the placing of the registers were left to the implementer.
module io_board_addr_irq_select
    import io_sel_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    input  wire host_bus_s         i_host_bus,
    input  wire logic [DATA_W-1:0] i_host_data,
    output logic      [DATA_W-1:0] o_host_data,
    output logic                   o_host_data_oe,
    input  wire logic [SW_W-1:0]   i_base_address_switch,
    input  wire logic [1:0]        i_interrupt_enable_jumper,
    input  wire logic [2:0]        i_interrupt_level_jumper,
    output chip_req_s              o_chip_req,
    input  wire logic [DATA_W-1:0] i_chip_rdata,
    input  wire logic              i_chip_service_request,
    input  wire logic [7:0]        i_port_c_lines,
    output logic      [IRQ_N-1:0]  o_irq_line,
    output logic      [IRQ_N-1:0]  o_irq_line_oe,
    input  wire logic [1:0]        i_reg_addr,
    input  wire logic [REG_W-1:0]  i_reg_wdata,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    output logic      [REG_W-1:0]  o_reg_rdata,
    output logic                   o_irq
);

    typedef enum logic [1:0] {CYC_IDLE, CYC_READ, CYC_WRITE} cyc_e;

    function automatic logic [IRQ_N-1:0] level_onehot(input logic [2:0] lvl);
        logic [IRQ_N-1:0] oh;
        oh = '0;
        if (lvl < 3'(IRQ_N)) begin
            oh[lvl] = 1'b1;
        end
        return oh;
    endfunction

    function automatic logic enable_line(input logic [1:0] sel,
                                         input logic [7:0] pc);
        logic en_n;
        case (sel)
            IE_BIT2: en_n = pc[PC_BIT2];
            IE_BIT4: en_n = pc[PC_BIT4];
            IE_BIT6: en_n = pc[PC_BIT6];
            default: en_n = 1'b1;
        endcase
        return en_n;
    endfunction

    host_bus_s         bus_s;
    logic [DATA_W-1:0] hdata_s;
    logic [SW_W-1:0]   sw_s;
    logic [1:0]        ie_s;
    logic [2:0]        lvl_s;

    sync_2ff #(.W($bits(host_bus_s))) u_sync_bus (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_async   (i_host_bus),
        .o_sync    (bus_s)
    );

    sync_2ff #(.W(DATA_W + SW_W + 5)) u_sync_cfg (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_async   ({i_host_data, i_base_address_switch,
                     i_interrupt_enable_jumper, i_interrupt_level_jumper}),
        .o_sync    ({hdata_s, sw_s, ie_s, lvl_s})
    );

    // straps stay at their defaults until the sync chain has filled
    logic [1:0]        warm;
    logic [SW_W-1:0]   cfg_base;
    logic [1:0]        cfg_ie;
    logic [2:0]        cfg_lvl;
    wire               warm_done = warm[1];

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            warm <= 2'h0;
        end else begin
            warm <= {warm[0], 1'b1};
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_base <= BASE_DEFAULT;
            cfg_ie   <= IE_DEFAULT;
            cfg_lvl  <= LVL_DEFAULT;
        end else if (warm_done) begin
            cfg_base <= sw_s;
            cfg_ie   <= ie_s;
            cfg_lvl  <= lvl_s;
        end
    end

    wire [SW_W-1:0] win_addr  = bus_s.addr[HOST_AW-1:WIN_LSB];
    wire            win_hit   = (win_addr == cfg_base);
    wire            io_cycle  = ~bus_s.aen;
    wire            rd_start  = win_hit & io_cycle & ~bus_s.ior_n;
    wire            wr_start  = win_hit & io_cycle & ~bus_s.iow_n
                                & bus_s.ior_n;
    wire            rsv_base  = (cfg_base <= BASE_RSV_MAX);
    wire            strobe_up = bus_s.ior_n & bus_s.iow_n;

    cyc_e              cyc;
    cyc_e              next_cyc;
    logic              rd_wait;
    chip_req_s         req;
    logic [DATA_W-1:0] hdata_out;
    logic              hdata_valid;

    always_comb begin
        next_cyc = cyc;
        case (cyc)
            CYC_IDLE: begin
                if (rd_start) begin
                    next_cyc = CYC_READ;
                end else if (wr_start) begin
                    next_cyc = CYC_WRITE;
                end
            end
            CYC_READ: begin
                if (bus_s.ior_n) begin
                    next_cyc = CYC_IDLE;
                end
            end
            CYC_WRITE: begin
                if (strobe_up) begin
                    next_cyc = CYC_IDLE;
                end
            end
            default: next_cyc = CYC_IDLE;
        endcase
    end

    wire take_rd = (cyc == CYC_IDLE) & (next_cyc == CYC_READ);
    wire take_wr = (cyc == CYC_IDLE) & (next_cyc == CYC_WRITE);

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cyc <= CYC_IDLE;
        end else begin
            cyc <= next_cyc;
        end
    end

    // one strobe per host cycle, however long the host holds it
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            req <= '0;
        end else begin
            req.rd <= take_rd;
            req.wr <= take_wr;
            if (take_rd | take_wr) begin
                req.addr  <= bus_s.addr[WIN_LSB-1:0];
                req.wdata <= hdata_s;
            end
        end
    end

    // chip answers in the cycle after its read strobe
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_wait     <= 1'b0;
            hdata_out   <= '0;
            hdata_valid <= 1'b0;
        end else begin
            rd_wait <= req.rd;
            if (rd_wait) begin
                hdata_out <= i_chip_rdata;
            end
            if (next_cyc != CYC_READ) begin
                hdata_valid <= 1'b0;
            end else if (rd_wait) begin
                hdata_valid <= 1'b1;
            end
        end
    end

    assign o_chip_req     = req;
    assign o_host_data    = hdata_out;
    assign o_host_data_oe = hdata_valid & (cyc == CYC_READ);

    // no-connect jumper reads as a high enable, which blocks everything
    wire              en_n      = enable_line(cfg_ie, i_port_c_lines);
    wire              gated_req = i_chip_service_request & ~en_n
                                  & (cfg_ie != IE_NC);
    wire [IRQ_N-1:0]  lvl_oh    = level_onehot(cfg_lvl);
    logic             irq_q;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= gated_req;
        end
    end

    // released lines float so another board can pull the same line
    assign o_irq_line    = lvl_oh & {IRQ_N{irq_q}};
    assign o_irq_line_oe = lvl_oh & {IRQ_N{irq_q}};

    logic [EV_W-1:0]  ev_status;
    logic [EV_W-1:0]  ev_enable;
    logic [REG_W-1:0] rdata;

    wire [EV_W-1:0] ev_set;
    assign ev_set[EV_READ]  = take_rd;
    assign ev_set[EV_WRITE] = take_wr;
    assign ev_set[EV_IRQ]   = gated_req & ~irq_q;
    assign ev_set[EV_RSV]   = (take_rd | take_wr) & rsv_base;

    wire             wr_en  = i_reg_wr & (i_reg_addr == REG_ENABLE);
    wire             wr_clr = i_reg_wr & (i_reg_addr == REG_CLEAR);
    wire [EV_W-1:0]  clr    = wr_clr ? i_reg_wdata[EV_W-1:0] : '0;

    wire [REG_W-1:0] cfg_word = REG_W'({cfg_lvl, cfg_ie, cfg_base});
    wire [REG_W-1:0] rd_mux   =
        (i_reg_addr == REG_STATUS) ? REG_W'(ev_status) :
        (i_reg_addr == REG_ENABLE) ? REG_W'(ev_enable) :
        (i_reg_addr == REG_CONFIG) ? cfg_word : '0;

    genvar g;
    generate
        for (g = 0; g < EV_W; g++) begin : g_ev
            // a set in the clearing cycle wins
            always_ff @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst) begin
                    ev_status[g] <= 1'b0;
                end else begin
                    ev_status[g] <= ev_set[g] | (ev_status[g] & ~clr[g]);
                end
            end
        end
    endgenerate

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ev_enable <= '0;
            rdata     <= '0;
        end else begin
            if (wr_en) begin
                ev_enable <= i_reg_wdata[EV_W-1:0];
            end
            rdata <= i_reg_rd ? rd_mux : '0;
        end
    end

    assign o_reg_rdata = rdata;
    assign o_irq       = |(ev_status & ev_enable);

    sequence s_read_taken;
        (cyc == CYC_IDLE) && rd_start;
    endsequence

    sequence s_read_answered;
        ##1 o_chip_req.rd ##1 rd_wait ##1 (hdata_out == $past(i_chip_rdata));
    endsequence

    property p_window_hit;
        @(posedge i_sys_clk) disable iff (i_rst)
        (cyc == CYC_IDLE) && io_cycle && !bus_s.ior_n
            && (bus_s.addr[HOST_AW-1:WIN_LSB] == cfg_base)
        |=> o_chip_req.rd;
    endproperty
    a_window_hit: assert property (p_window_hit)
        else $error("selected read gave no chip strobe");
    property p_no_foreign;
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_chip_req.rd || o_chip_req.wr)
        |-> ($past(bus_s.addr[HOST_AW-1:WIN_LSB]) == $past(cfg_base));
    endproperty
    a_no_foreign: assert property (p_no_foreign)
        else $error("chip strobe for an address outside the window");
    property p_reg_pick;
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_chip_req.rd || o_chip_req.wr)
        |-> (o_chip_req.addr == $past(bus_s.addr[WIN_LSB-1:0]));
    endproperty
    a_reg_pick: assert property (p_reg_pick)
        else $error("onboard register index differs from a1..a0");
    property p_no_dma;
        @(posedge i_sys_clk) disable iff (i_rst)
        bus_s.aen |=> !(o_chip_req.rd || o_chip_req.wr);
    endproperty
    a_no_dma: assert property (p_no_dma)
        else $error("chip strobe during a dma cycle");
    property p_read_path;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_read_taken ##1 bus_s.ior_n == 1'b0 ##1 bus_s.ior_n == 1'b0
        |-> ##1 o_host_data_oe;
    endproperty
    a_read_path: assert property (p_read_path)
        else $error("read data not driven in a held read");
    property p_read_data;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_read_taken |-> s_read_answered;
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("host read data is not the chip answer");
    property p_oe_only_read;
        @(posedge i_sys_clk) disable iff (i_rst)
        o_host_data_oe |-> (cyc == CYC_READ) && !o_chip_req.wr;
    endproperty
    a_oe_only_read: assert property (p_oe_only_read)
        else $error("data driven outside a read");
    property p_enable_low;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_chip_service_request && (cfg_ie == IE_BIT4)
            && !i_port_c_lines[PC_BIT4]
        |=> (o_irq_line_oe == lvl_oh);
    endproperty
    a_enable_low: assert property (p_enable_low)
        else $error("enabled request did not reach the irq line");
    property p_enable_high;
        @(posedge i_sys_clk) disable iff (i_rst)
        (cfg_ie == IE_BIT6) && i_port_c_lines[PC_BIT6] && $stable(cfg_ie)
        |=> (o_irq_line_oe == '0);
    endproperty
    a_enable_high: assert property (p_enable_high)
        else $error("request passed with its enable line high");
    property p_nc_blocks;
        @(posedge i_sys_clk) disable iff (i_rst)
        (cfg_ie == IE_NC) |=> (o_irq_line_oe == '0);
    endproperty
    a_nc_blocks: assert property (p_nc_blocks)
        else $error("request passed with no enable connection");
    property p_one_line;
        @(posedge i_sys_clk) disable iff (i_rst)
        $onehot0(o_irq_line_oe) && ((o_irq_line_oe & ~lvl_oh) == '0);
    endproperty
    a_one_line: assert property (p_one_line)
        else $error("irq driven on more than the selected line");
    property p_defaults;
        @(posedge i_sys_clk)
        $fell(i_rst) |-> (cfg_base == BASE_DEFAULT)
            && (cfg_ie == IE_DEFAULT) && (cfg_lvl == LVL_DEFAULT);
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("configuration not at defaults after reset");
    property p_sticky;
        @(posedge i_sys_clk) disable iff (i_rst)
        ev_set[EV_RSV] |=> ev_status[EV_RSV]
            ##1 (ev_status[EV_RSV] || $past(clr[EV_RSV]));
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("system space event did not stick");

endmodule // io_board_addr_irq_select

// *** src/io_sel_pkg.sv ***
package io_sel_pkg;

    // host address and strobes as seen on the expansion channel
    typedef struct packed {
        logic [9:0] addr;
        logic       ior_n;
        logic       iow_n;
        logic       aen;
    } host_bus_s;

    // request toward the onboard parallel chip
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [1:0] addr;
        logic [7:0] wdata;
    } chip_req_s;

    localparam int          HOST_AW       = 10;
    localparam int          WIN_LSB       = 2;
    localparam int          SW_W          = 8;
    localparam int          DATA_W        = 8;
    localparam int          REG_W         = 16;
    localparam int          EV_W          = 4;
    localparam int          IRQ_N         = 6;

    // base 210h on lines a9..a2
    localparam logic [7:0]  BASE_DEFAULT  = 8'h84;
    // bases up to 0FFh belong to the system
    localparam logic [7:0]  BASE_RSV_MAX  = 8'h3F;

    // interrupt enable jumper codes
    localparam logic [1:0]  IE_NC         = 2'h0;
    localparam logic [1:0]  IE_BIT2       = 2'h1;
    localparam logic [1:0]  IE_BIT4       = 2'h2;
    localparam logic [1:0]  IE_BIT6       = 2'h3;
    localparam logic [1:0]  IE_DEFAULT    = IE_BIT4;
    localparam int          PC_BIT2       = 2;
    localparam int          PC_BIT4       = 4;
    localparam int          PC_BIT6       = 6;

    // interrupt level jumper codes, index into the irq line vector
    localparam logic [2:0]  LVL_IRQ3      = 3'h0;
    localparam logic [2:0]  LVL_IRQ4      = 3'h1;
    localparam logic [2:0]  LVL_IRQ5      = 3'h2;
    localparam logic [2:0]  LVL_IRQ6      = 3'h3;
    localparam logic [2:0]  LVL_IRQ7      = 3'h4;
    localparam logic [2:0]  LVL_IRQ9      = 3'h5;
    localparam logic [2:0]  LVL_DEFAULT   = LVL_IRQ5;

    // software register indices
    localparam logic [1:0]  REG_STATUS    = 2'h0;
    localparam logic [1:0]  REG_ENABLE    = 2'h1;
    localparam logic [1:0]  REG_CLEAR     = 2'h2;
    localparam logic [1:0]  REG_CONFIG    = 2'h3;

    // status bit positions
    localparam int          EV_READ       = 0;
    localparam int          EV_WRITE      = 1;
    localparam int          EV_IRQ        = 2;
    localparam int          EV_RSV        = 3;

    // config readback field positions
    localparam int          CFG_BASE_LSB  = 0;
    localparam int          CFG_IE_LSB    = 8;
    localparam int          CFG_LVL_LSB   = 10;

endpackage

// *** src/sync_2ff.sv ***
module sync_2ff
    import io_sel_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta;

    // first stage is read by the second stage only
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule // sync_2ff

// *** bench/host_channel_model.sv ***
module host_channel_model
    import io_sel_pkg::*;
(
    input  wire logic              i_sys_clk,
    output host_bus_s              o_host_bus,
    output logic      [DATA_W-1:0] o_host_data,
    input  wire logic [DATA_W-1:0] i_board_data,
    input  wire logic              i_board_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_host_bus  = '{addr: 10'h3FF, ior_n: 1'b1, iow_n: 1'b1, aen: 1'b0};
        o_host_data = 8'h00;
    end

    // one host i/o cycle; strobe held long enough for the sync chain
    task automatic io_cycle(input logic rd, input logic [9:0] a,
                            input logic dma, input logic [7:0] wd,
                            output logic [7:0] rdat, output logic seen);
        int n;
        begin
            seen = 1'b0;
            rdat = 8'h00;
            @(posedge i_sys_clk);
            o_host_bus.addr  <= a;
            o_host_bus.aen   <= dma;
            o_host_bus.ior_n <= !rd;
            o_host_bus.iow_n <= rd;
            if (!rd) begin
                o_host_data <= wd;
            end
            for (n = 0; n < 10; n++) begin
                @(posedge i_sys_clk);
                if (i_board_data_oe === 1'b1 && !seen) begin
                    seen = 1'b1;
                    rdat = i_board_data;
                end
            end
            // released lines show garbage, never the old value
            o_host_bus.ior_n <= 1'b1;
            o_host_bus.iow_n <= 1'b1;
            o_host_bus.addr  <= ~a;
            o_host_data      <= ~o_host_data;
            repeat (8) @(posedge i_sys_clk);
        end
    endtask
endmodule // host_channel_model

// *** bench/test_io_board_addr_irq_select.sv ***
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
    err_count++; $display("Error %s expected %0h seen %0h", nm, ex, got); \
    end end

module test_io_board_addr_irq_select
    import io_sel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic             sys_clk;
    logic             rst;
    host_bus_s        host_bus;
    logic [7:0]       host_wdata;
    logic [7:0]       host_rdata;
    logic             host_oe;
    logic [7:0]       base_sw;
    logic [1:0]       ie_j;
    logic [2:0]       lvl_j;
    chip_req_s        chip_req;
    chip_req_s        last_req;
    logic [7:0]       chip_rdata;
    logic             svc_req;
    logic [7:0]       port_c;
    logic [IRQ_N-1:0] irq_line;
    logic [IRQ_N-1:0] irq_oe;
    logic [IRQ_N-1:0] exp_oe;
    logic [1:0]       reg_addr;
    logic [15:0]      reg_wdata;
    logic [15:0]      reg_rdata;
    logic             reg_wr;
    logic             reg_rd;
    logic             irq;
    logic [9:0]       miss_a [5];
    int               err_count = 0;
    int               compares = 0;
    int               rd_cnt = 0;
    int               wr_cnt = 0;
    int               bitn;

    io_board_addr_irq_select i_dut (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_host_bus(host_bus),
        .i_host_data(host_wdata), .o_host_data(host_rdata),
        .o_host_data_oe(host_oe), .i_base_address_switch(base_sw),
        .i_interrupt_enable_jumper(ie_j), .i_interrupt_level_jumper(lvl_j),
        .o_chip_req(chip_req), .i_chip_rdata(chip_rdata),
        .i_chip_service_request(svc_req), .i_port_c_lines(port_c),
        .o_irq_line(irq_line), .o_irq_line_oe(irq_oe), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata), .o_irq(irq));

    host_channel_model i_host (
        .i_sys_clk(sys_clk), .o_host_bus(host_bus), .o_host_data(host_wdata),
        .i_board_data(host_rdata), .i_board_data_oe(host_oe));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (chip_req.rd === 1'b1) begin
            rd_cnt++;
            last_req = chip_req;
        end
        if (chip_req.wr === 1'b1) begin
            wr_cnt++;
            last_req = chip_req;
        end
    end

    task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_check(input logic [1:0] a, input logic [15:0] ex);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        `CHK("reg_rdata", ex, reg_rdata)
        @(posedge sys_clk);
    endtask

    task automatic host_chk(input logic rd, input logic [9:0] a,
                            input logic dma, input logic [7:0] wd,
                            input logic hit);
        int         r0;
        int         w0;
        logic [7:0] rdat;
        logic       seen;
        begin
            r0 = rd_cnt;
            w0 = wr_cnt;
            i_host.io_cycle(rd, a, dma, wd, rdat, seen);
            `CHK("chip_rd_count", r0 + int'(hit && rd), rd_cnt)
            `CHK("chip_wr_count", w0 + int'(hit && !rd), wr_cnt)
            `CHK("host_data_oe_seen", hit && rd, seen)
            if (hit) begin
                `CHK("chip_addr", a[1:0], last_req.addr)
                if (rd) `CHK("host_rdata", chip_rdata, rdat)
                else    `CHK("chip_wdata", wd, last_req.wdata)
            end
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        // straps steady well before reset ends
        rst = 1'b1; base_sw = BASE_DEFAULT; ie_j = IE_DEFAULT;
        lvl_j = LVL_DEFAULT; chip_rdata = 8'h00; svc_req = 1'b0;
        port_c = 8'hFF; reg_addr = 2'h0; reg_wdata = 16'h0000;
        reg_wr = 1'b0; reg_rd = 1'b0; last_req = '0;
        miss_a = '{10'h20F, 10'h214, 10'h010, 10'h310, 10'h290};
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        reg_check(REG_CONFIG,
                  {3'h0, LVL_DEFAULT, IE_DEFAULT, BASE_DEFAULT});
        reg_check(REG_STATUS, 16'h0000);
        reg_check(REG_ENABLE, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            chip_rdata <= 8'h5A ^ 8'(i);
            host_chk(1'b1, 10'h210 + 10'(i), 1'b0, 8'h00, 1'b1);
        end
        host_chk(1'b0, 10'h212, 1'b0, 8'hC3, 1'b1);
        foreach (miss_a[i]) begin
            host_chk(1'b1, miss_a[i], 1'b0, 8'h00, 1'b0);
        end
        host_chk(1'b1, 10'h210, 1'b1, 8'h00, 1'b0);
        host_chk(1'b0, 10'h211, 1'b1, 8'h11, 1'b0);
        reg_check(REG_STATUS, 16'h0003);
        reg_write(REG_CLEAR, 16'h0001);
        reg_write(REG_STATUS, 16'h000F);
        reg_check(REG_STATUS, 16'h0002);
        reg_check(REG_CLEAR, 16'h0000);
        reg_write(REG_CLEAR, 16'h000F);
        base_sw <= 8'hFF;
        repeat (6) @(posedge sys_clk);
        chip_rdata <= 8'hA5;
        host_chk(1'b1, 10'h3FF, 1'b0, 8'h00, 1'b1);
        host_chk(1'b1, 10'h3FB, 1'b0, 8'h00, 1'b0);
        reg_write(REG_CLEAR, 16'h000F);
        base_sw <= 8'h00;
        repeat (6) @(posedge sys_clk);
        host_chk(1'b1, 10'h001, 1'b0, 8'h00, 1'b1);
        reg_check(REG_STATUS, 16'h0009);
        base_sw <= BASE_DEFAULT;
        reg_write(REG_CLEAR, 16'h000F);
        reg_write(REG_ENABLE, 16'h0004);
        for (int ie = 0; ie < 4; ie++) begin
            // level codes 6 and 7 select no line at all
            for (int lv = 0; lv < 8; lv++) begin
                ie_j   <= 2'(ie);
                lvl_j  <= 3'(lv);
                bitn   = (ie == 1) ? PC_BIT2 : (ie == 2) ? PC_BIT4 : PC_BIT6;
                port_c <= (ie == 0) ? 8'h00 : ~(8'h01 << bitn);
                exp_oe = (ie == 0) ? '0 : IRQ_N'(1) << lv;
                repeat (6) @(posedge sys_clk);
                `CHK("irq_oe_no_request", 6'h00, irq_oe)
                svc_req <= 1'b1;
                repeat (4) @(posedge sys_clk);
                `CHK("irq_oe", exp_oe, irq_oe)
                `CHK("irq_line", exp_oe, irq_line & exp_oe)
                port_c <= 8'h01 << bitn;
                repeat (4) @(posedge sys_clk);
                `CHK("irq_oe_blocked", 6'h00, irq_oe)
                svc_req <= 1'b0;
            end
        end
        `CHK("o_irq_enabled", 1'b1, irq)
        reg_write(REG_ENABLE, 16'h0000);
        @(posedge sys_clk);
        `CHK("o_irq_masked", 1'b0, irq)
        reg_write(REG_ENABLE, 16'h0004);
        reg_write(REG_CLEAR, 16'h0004);
        @(posedge sys_clk);
        `CHK("o_irq_cleared", 1'b0, irq)
        reg_check(REG_STATUS, 16'h0000);
        report_and_stop();
    end
endmodule // test_io_board_addr_irq_select
